// ==== logic/external_memory_interface.sv ====
// Contract
// - trailing latch pulse in final period only if next instruction touches data memory
// - enable bit hands address, data, latch and strobe pins to memory use
// - cleared enable returns pins to port value and direction
// - legacy mode: upper wait low bit adds one strobe cycle
// - reserved control bits read zero; software writes zeros
// - sector limit field zero means a single external sector
// - limit values 1..7 put boundary at multiples of 0x2000
// - single sector uses the upper-sector wait setting
// - upper wait is control A bit 1 high, mcu control bit 6 low
// - lower wait comes from control A bits 3..2
// - wait codes: none, one, two, two plus one before next address
// - bus keeper holds last level on the muxed bus when released
// - bus keeper works even with the interface disabled
// - high mask value releases high-address pins from the top down
// - released high pins follow their port registers
// - first 4352 bytes are internal, no external strobes
// - legacy mode internal space is 4096 bytes
// - address valid at latch fall; latch low during transfer
// - internal accesses toggle address, data, latch but not strobes
// - legacy mode: two wait settings, fixed high width, no sectors, no keeper
//
// top of the external memory interface: core access port, pin sequencer
// assumes the core holds acc_req until acc_done and drives port registers
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module external_memory_interface
  import external_memory_interface_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic legacy_mode,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic [15:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic acc_next_mem,
  output logic acc_done,
  output logic [7:0] acc_rdata,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_dir,
  input wire logic [7:0] port_c_out,
  input wire logic [7:0] port_c_dir,
  input wire logic [2:0] port_g_out,
  input wire logic [2:0] port_g_dir,
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic [7:0] ad_oe,
  output logic [7:0] high_address_out,
  output logic [7:0] high_address_oe,
  output logic latch_out,
  output logic latch_oe,
  output logic rd_n_out,
  output logic rd_n_oe,
  output logic wr_n_out,
  output logic wr_n_oe
);
  external_memory_interface_cfg_if cfg ();
  cyc_state_type state_r;
  cyc_state_type state_nxt;
  logic [1:0] wait_r;
  logic [1:0] wait_cnt_r;
  logic ext_r;
  logic we_r;
  logic [15:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] keep_r;
  logic [7:0] high_drive;
  logic is_ext;
  logic [1:0] sel_wait;
  logic tail_pulse;
  logic take;
  logic [7:0] mem_ad_out;
  logic mem_ad_oe;
  logic mem_latch;
  logic mem_rd_n;
  logic mem_wr_n;

  external_memory_interface_regs u_regs (
    .core_clk(core_clk),
    .resetn(resetn),
    .legacy_mode(legacy_mode),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .cfg(cfg.regs)
  );

  // boundary for a sector limit code, zero meaning no lower sector
  function automatic logic in_lower(input logic [15:0] a, input logic [2:0] lim);
    logic [15:0] bound;
    bound = 16'({lim, 13'h0000});
    in_lower = (lim != 3'h0) && (a < bound);
  endfunction

  // internal region shrinks in legacy mode
  assign is_ext = cfg.legacy_mode ? (acc_addr >= INTERNAL_TOP_LEGACY) :
    (acc_addr >= INTERNAL_TOP);

  // the core still holds acc_req on the done edge, so that edge must not start a new cycle
  assign take = acc_req && cfg.external_memory_interface_enable && !acc_done;

  // pick the sector's wait code; one sector means upper setting
  always_comb begin
    if (in_lower(acc_addr, cfg.sector_limit)) begin
      sel_wait = cfg.lower_wait;
    end else begin
      sel_wait = cfg.upper_wait;
    end
  end

  // next-state logic of the bus cycle
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (take) state_nxt = ST_ADDR;
      ST_ADDR: state_nxt = ST_STROBE;
      ST_STROBE: state_nxt = (wait_r == WAIT_NONE) ? ST_TAIL : ST_WAIT;
      ST_WAIT: begin
        if (wait_cnt_r == 2'h1 || wait_r == WAIT_ONE) begin
          state_nxt = (wait_r == WAIT_TWO_HOLD) ? ST_HOLD : ST_TAIL;
        end
      end
      ST_HOLD: state_nxt = ST_TAIL;
      ST_TAIL: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // capture the access at the address phase
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wait_r <= WAIT_NONE;
      ext_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= 16'h0000;
      wdata_r <= 8'h00;
    end else if (state_r == ST_IDLE && take) begin
      wait_r <= is_ext ? sel_wait : WAIT_NONE;
      ext_r <= is_ext;
      we_r <= acc_we;
      addr_r <= acc_addr;
      wdata_r <= acc_wdata;
    end
  end

  // counts the extra strobe cycles
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wait_cnt_r <= 2'h0;
    end else if (state_r == ST_STROBE) begin
      wait_cnt_r <= 2'h0;
    end else if (state_r == ST_WAIT) begin
      wait_cnt_r <= wait_cnt_r + 2'h1;
    end
  end

  // pin values of the memory function for the next cycle
  assign tail_pulse = (state_nxt == ST_TAIL) ? acc_next_mem : 1'b0;
  always_comb begin
    mem_ad_out = (state_nxt == ST_ADDR) ? acc_addr[7:0] : addr_r[7:0];
    mem_ad_oe = 1'b0;
    mem_latch = 1'b0;
    mem_rd_n = 1'b1;
    mem_wr_n = 1'b1;
    unique case (state_nxt)
      ST_IDLE: ;
      ST_ADDR: begin
        mem_ad_oe = 1'b1; // address valid while latch high, falls after
        mem_latch = 1'b1;
      end
      ST_STROBE, ST_WAIT: begin
        mem_ad_out = wdata_r;
        mem_ad_oe = we_r;
        // strobes only for external targets
        mem_rd_n = ~(ext_r & ~we_r);
        mem_wr_n = ~(ext_r & we_r);
      end
      ST_HOLD: ;
      ST_TAIL: mem_latch = tail_pulse;
    endcase
  end

  // high-address drive map: mask n releases the top n pins for n up to 6; mask 7 releases all eight
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      high_drive[i] = (cfg.high_mask == 3'h7) ? 1'b0 : (i < 8 - int'(cfg.high_mask));
    end
  end

  // keeper remembers the last level seen on the muxed bus
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      keep_r <= 8'h00;
    end else begin
      keep_r <= ad_oe_any() ? ad_out : ad_in;
    end
  end

  function automatic logic ad_oe_any();
    ad_oe_any = |ad_oe;
  endfunction

  // registered pin muxing between memory function and port function
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ad_out <= 8'h00;
      ad_oe <= 8'h00;
      high_address_out <= 8'h00;
      high_address_oe <= 8'h00;
      latch_out <= 1'b0;
      latch_oe <= 1'b0;
      rd_n_out <= 1'b1;
      rd_n_oe <= 1'b0;
      wr_n_out <= 1'b1;
      wr_n_oe <= 1'b0;
    end else if (cfg.external_memory_interface_enable) begin
      // memory function overrides direction settings
      if (mem_ad_oe) begin
        ad_out <= mem_ad_out;
        ad_oe <= 8'hFF;
      end else if (cfg.bus_keeper_enable && mem_rd_n) begin
        // never during a read strobe, where the memory owns the bus
        ad_out <= keep_r; // held instead of floating
        ad_oe <= 8'hFF;
      end else begin
        ad_out <= mem_ad_out;
        ad_oe <= 8'h00;
      end
      for (int i = 0; i < 8; i++) begin
        // released pins behave as port pins
        high_address_out[i] <= high_drive[i] ?
          (state_nxt == ST_ADDR ? acc_addr[8 + i] : addr_r[8 + i]) : port_c_out[i];
        high_address_oe[i] <= high_drive[i] ? 1'b1 : port_c_dir[i];
      end
      latch_out <= mem_latch;
      latch_oe <= 1'b1;
      rd_n_out <= mem_rd_n;
      rd_n_oe <= 1'b1;
      wr_n_out <= mem_wr_n;
      wr_n_oe <= 1'b1;
    end else begin
      // plain port behaviour; keeper still holds released lines
      for (int i = 0; i < 8; i++) begin
        ad_out[i] <= (port_a_dir[i] || !cfg.bus_keeper_enable) ? port_a_out[i] : keep_r[i];
        ad_oe[i] <= port_a_dir[i] | cfg.bus_keeper_enable;
      end
      high_address_out <= port_c_out;
      high_address_oe <= port_c_dir;
      wr_n_out <= port_g_out[0];
      wr_n_oe <= port_g_dir[0];
      rd_n_out <= port_g_out[1];
      rd_n_oe <= port_g_dir[1];
      latch_out <= port_g_out[2];
      latch_oe <= port_g_dir[2];
    end
  end

  // completion handshake and read data capture at the end of the strobe
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc_done <= 1'b0;
      acc_rdata <= 8'h00;
    end else begin
      acc_done <= (state_r == ST_TAIL) || (state_r == ST_IDLE && acc_req &&
        !cfg.external_memory_interface_enable && !acc_done);
      if ((state_r == ST_STROBE && wait_r == WAIT_NONE) ||
          (state_r == ST_WAIT && state_nxt != ST_WAIT)) begin
        acc_rdata <= ad_in;
      end
    end
  end

  assign cfg.busy = (state_r != ST_IDLE);

  // strobe sequences per wait code
  sequence strobe_len1;
    (!rd_n_out || !wr_n_out) ##1 (rd_n_out && wr_n_out);
  endsequence
  sequence strobe_len2;
    (!rd_n_out || !wr_n_out) [*2] ##1 (rd_n_out && wr_n_out);
  endsequence
  sequence strobe_len3;
    (!rd_n_out || !wr_n_out) [*3] ##1 (rd_n_out && wr_n_out);
  endsequence

  chk_no_wait_strobe: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_r == ST_ADDR && ext_r && wait_r == WAIT_NONE && cfg.external_memory_interface_enable) |=> strobe_len1)
    else $error("no-wait strobe not one cycle");
  chk_one_wait_strobe: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_r == ST_ADDR && ext_r && wait_r == WAIT_ONE && cfg.external_memory_interface_enable) |=> strobe_len2)
    else $error("one-wait strobe not two cycles");
  chk_two_wait_strobe: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_r == ST_ADDR && ext_r && wait_r[1] && cfg.external_memory_interface_enable) |=> strobe_len3)
    else $error("two-wait strobe not three cycles");
  chk_internal_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_r == ST_ADDR && !ext_r) |-> (rd_n_out && wr_n_out) [*2])
    else $error("strobe toggled on internal access");
  chk_latch_addr: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_r == ST_ADDR && cfg.external_memory_interface_enable) |-> latch_out && ad_oe == 8'hFF ##1 !latch_out)
    else $error("latch not high with address");
  chk_legacy_sector: assert property (@(posedge core_clk) disable iff (!resetn)
    legacy_mode |-> cfg.sector_limit == 3'h0 && cfg.high_mask == 3'h0 && !cfg.upper_wait[1])
    else $error("legacy mode feature leaked");
  chk_disabled_ports: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(!cfg.external_memory_interface_enable) |-> high_address_out == $past(port_c_out))
    else $error("high pins not on port when disabled");
  chk_internal_target: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_r == ST_IDLE && take && acc_addr < INTERNAL_TOP_LEGACY)
    |=> !ext_r)
    else $error("low address treated as external");
  chk_high_release: assert property (@(posedge core_clk) disable iff (!resetn)
    (cfg.external_memory_interface_enable && cfg.high_mask == 3'h7) |=> high_address_oe == $past(port_c_dir))
    else $error("masked high pins still driven");
endmodule
`default_nettype wire

// ==== logic/external_memory_interface_regs.sv ====
// register file: three control registers and a status word on Avalon-MM
// assumes the master holds its request until waitrequest is low
`timescale 1ns/100ps
`default_nettype none
module external_memory_interface_regs
  import external_memory_interface_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic legacy_mode,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  external_memory_interface_cfg_if.regs cfg
);
  logic [7:0] mcu_control_r;
  logic [7:0] ext_mem_control_a_r;
  logic [7:0] ext_mem_control_b_r;
  logic ack_r;
  logic wr_lane;

  // one wait cycle per access: request taken, answered the next edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  // a write lands only on the answering edge, where the master sees waitrequest low
  assign wr_lane = avs_write & ack_r & avs_byteenable[0];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // control writes; reserved bits are never stored
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mcu_control_r <= RST_MCU_CONTROL;
      ext_mem_control_a_r <= RST_CONTROL_A;
      ext_mem_control_b_r <= RST_CONTROL_B;
    end else if (wr_lane) begin
      unique case (avs_address)
        OFS_MCU_CONTROL: mcu_control_r <= avs_writedata[7:0];
        OFS_CONTROL_A: ext_mem_control_a_r <= avs_writedata[7:0] & MASK_CONTROL_A;
        OFS_CONTROL_B: ext_mem_control_b_r <= avs_writedata[7:0] & MASK_CONTROL_B;
        default: ;
      endcase
    end
  end

  // read mux; unmapped offsets read zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else begin
      unique case (avs_address)
        OFS_MCU_CONTROL: avs_readdata <= {24'h000000, mcu_control_r};
        OFS_CONTROL_A: avs_readdata <= {24'h000000, ext_mem_control_a_r};
        OFS_CONTROL_B: avs_readdata <= {24'h000000, ext_mem_control_b_r};
        OFS_STATUS: avs_readdata <= {30'h0000_0000, legacy_mode, cfg.busy};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // legacy mode hides the extra registers' features
  assign cfg.external_memory_interface_enable = mcu_control_r[BIT_EXTERNAL_MEMORY_INTERFACE_ENABLE];
  assign cfg.legacy_mode = legacy_mode;
  assign cfg.upper_wait = legacy_mode ? {1'b0, mcu_control_r[BIT_UPPER_WAIT_LOW]} :
    {ext_mem_control_a_r[BIT_UPPER_WAIT_HIGH], mcu_control_r[BIT_UPPER_WAIT_LOW]};
  assign cfg.lower_wait = ext_mem_control_a_r[POS_LOWER_WAIT +: 2];
  assign cfg.sector_limit = legacy_mode ? 3'h0 : ext_mem_control_a_r[POS_SECTOR_LIMIT +: 3];
  assign cfg.bus_keeper_enable = ~legacy_mode & ext_mem_control_b_r[BIT_BUS_KEEPER];
  assign cfg.high_mask = legacy_mode ? 3'h0 : ext_mem_control_b_r[POS_HIGH_MASK +: 3];

  chk_reserved_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    ext_mem_control_a_r[7] == 1'b0 && ext_mem_control_a_r[0] == 1'b0 &&
    ext_mem_control_b_r[6:4] == 3'h0)
    else $error("reserved control bit stored");
  chk_bus_answer: assert property (@(posedge core_clk) disable iff (!resetn)
    (avs_read && avs_waitrequest) |=> !avs_waitrequest)
    else $error("register read not answered in one cycle");
endmodule
`default_nettype wire

// ==== shared/external_memory_interface_cfg_if.sv ====
// configuration bundle from the register file to the bus sequencer
// assumes both ends share core_clk
`timescale 1ns/100ps
`default_nettype none
interface external_memory_interface_cfg_if;
  logic external_memory_interface_enable;
  logic legacy_mode;
  logic [1:0] upper_wait;
  logic [1:0] lower_wait;
  logic [2:0] sector_limit;
  logic bus_keeper_enable;
  logic [2:0] high_mask;
  logic busy;
  modport regs (output external_memory_interface_enable, legacy_mode, upper_wait, lower_wait, sector_limit,
    output bus_keeper_enable, high_mask, input busy);
  modport seq (input external_memory_interface_enable, legacy_mode, upper_wait, lower_wait, sector_limit,
    input bus_keeper_enable, high_mask, output busy);
endinterface
`default_nettype wire

// ==== shared/external_memory_interface_pkg.sv ====
// package for the external memory interface: register map, fields, timing
// assumes one 40 MHz core clock and an Avalon-MM register slave
package external_memory_interface_pkg;
  localparam int CLK_MHZ = 40;
  // register byte addresses on the avalon word bus
  localparam logic [3:0] OFS_MCU_CONTROL = 4'h0;
  localparam logic [3:0] OFS_CONTROL_A = 4'h4;
  localparam logic [3:0] OFS_CONTROL_B = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  // reset values
  localparam logic [7:0] RST_MCU_CONTROL = 8'h00;
  localparam logic [7:0] RST_CONTROL_A = 8'h00;
  localparam logic [7:0] RST_CONTROL_B = 8'h00;
  // field positions
  localparam int BIT_EXTERNAL_MEMORY_INTERFACE_ENABLE = 7;
  localparam int BIT_UPPER_WAIT_LOW = 6;
  localparam int BIT_UPPER_WAIT_HIGH = 1;
  localparam int POS_LOWER_WAIT = 2;
  localparam int POS_SECTOR_LIMIT = 4;
  localparam int BIT_BUS_KEEPER = 7;
  localparam int POS_HIGH_MASK = 0;
  // writable bit masks; everything else is reserved and reads zero
  localparam logic [7:0] MASK_CONTROL_A = 8'h7E;
  localparam logic [7:0] MASK_CONTROL_B = 8'h87;
  // address map
  localparam logic [15:0] INTERNAL_TOP = 16'h1100;
  localparam logic [15:0] INTERNAL_TOP_LEGACY = 16'h1000;
  localparam logic [2:0] SECTOR_SHIFT = 3'h5;
  // wait codes
  localparam logic [1:0] WAIT_NONE = 2'h0;
  localparam logic [1:0] WAIT_ONE = 2'h1;
  localparam logic [1:0] WAIT_TWO = 2'h2;
  localparam logic [1:0] WAIT_TWO_HOLD = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_STROBE, ST_WAIT, ST_HOLD, ST_TAIL
  } cyc_state_type;
endpackage

// ==== testbench/sram_model.sv ====
// behavioural external sram behind an address latch on the muxed bus
// assumes active-low strobes and a latch that is transparent while latch_out is high
`timescale 1ns/100ps
`default_nettype none
module sram_model (
  input wire logic core_clk,
  input wire logic [1:0] lag,
  input wire logic [7:0] ad_out,
  input wire logic [7:0] ad_oe,
  input wire logic [7:0] high_address_out,
  input wire logic latch_out,
  input wire logic rd_n_out,
  input wire logic rd_n_oe,
  input wire logic wr_n_out,
  input wire logic wr_n_oe,
  output logic [7:0] ad_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] low_r = 8'h00;
  logic [7:0] last_r = 8'h00;
  logic [1:0] age_r = 2'h0;
  logic reading;
  // low address byte taken while the latch is open, held after its fall
  // sampled at the clock: latch fall and bus change share one edge and would race
  always @(posedge core_clk) if (latch_out) low_r <= ad_out;
  assign reading = rd_n_oe && !rd_n_out;
  // write data is taken on every clock of the active write strobe
  always @(posedge core_clk) if (wr_n_oe && !wr_n_out) mem[{high_address_out, low_r}] <= ad_out;
  // strobe age lets a slow part show junk until lag cycles have passed
  always @(posedge core_clk) begin
    age_r <= reading ? ((age_r == 2'h3) ? age_r : age_r + 2'h1) : 2'h0;
    last_r <= ad_in;
  end
  // released lines carry no level, so show the inverse of the last one
  assign ad_in = reading ? ((age_r >= lag) ? mem[{high_address_out, low_r}] :
    ~mem[{high_address_out, low_r}]) : ((ad_oe & ad_out) | (~ad_oe & ~last_r));
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the external memory interface top
// assumes the sram model on the far side and avalon register access
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import external_memory_interface_pkg::*;
  logic core_clk, resetn, legacy_mode, avs_read, avs_write, avs_waitrequest;
  logic acc_req, acc_we, acc_next_mem, acc_done;
  logic latch_out, latch_oe, rd_n_out, rd_n_oe, wr_n_out, wr_n_oe;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [15:0] acc_addr;
  logic [7:0] acc_wdata, acc_rdata, port_a_dir, port_c_out, port_c_dir, ad_in, ad_out, ad_oe;
  logic [7:0] high_address_out, high_address_oe, hoe_seen, q;
  logic [1:0] lag;
  int fails, total_checks, rd_cnt, wr_cnt, ale_cnt, lat, lat0, a0;
  external_memory_interface external_memory_interface_i (.core_clk, .resetn, .legacy_mode,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .acc_req, .acc_we, .acc_addr, .acc_wdata, .acc_next_mem, .acc_done,
    .acc_rdata, .port_a_out(8'h00), .port_a_dir, .port_c_out, .port_c_dir, .port_g_out(3'h0),
    .port_g_dir(3'h0), .ad_in, .ad_out, .ad_oe, .high_address_out, .high_address_oe,
    .latch_out, .latch_oe, .rd_n_out, .rd_n_oe, .wr_n_out, .wr_n_oe);
  sram_model sram_model_i (.core_clk, .lag, .ad_out, .ad_oe, .high_address_out, .latch_out,
    .rd_n_out, .rd_n_oe, .wr_n_out, .wr_n_oe, .ad_in);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // pin activity counters, sampled before the edge's own updates land
  always @(posedge core_clk) begin
    if (rd_n_oe && !rd_n_out) rd_cnt++;
    if (wr_n_oe && !wr_n_out) begin
      wr_cnt++;
      hoe_seen = high_address_oe;
    end
    if (latch_out) ale_cnt++;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // one avalon transfer; held until waitrequest is seen low at an edge
  task automatic reg_acc(input logic we, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= we;
    avs_read <= !we;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      fails++;
      summarize();
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  // one core access; request held until done, then a few idle cycles for the tail
  task automatic access(input logic we, input logic [15:0] a, input logic [7:0] d,
      input logic nm);
    acc_we <= we;
    acc_addr <= a;
    acc_wdata <= d;
    acc_next_mem <= nm;
    acc_req <= 1'b1;
    rd_cnt = 0;
    wr_cnt = 0;
    ale_cnt = 0;
    lat = 0;
    do begin
      @(posedge core_clk);
      lat++;
    end while (acc_done !== 1'b1 && lat < 60);
    if (lat >= 60) begin
      fails++;
      summarize();
    end
    q = acc_rdata;
    acc_req <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic set_cfg(input logic [1:0] uw, input logic [1:0] lw, input logic [2:0] lim);
    reg_acc(1'b1, OFS_MCU_CONTROL, {1'b1, uw[0], 6'h00});
    reg_acc(1'b1, OFS_CONTROL_A, {1'b0, lim, lw, uw[1], 1'b0});
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    summarize();
  end
  initial begin
    fails = 0;
    total_checks = 0;
    resetn = 1'b0;
    legacy_mode = 1'b0;
    {avs_read, avs_write, acc_req, acc_we, acc_next_mem} = 5'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h00000000;
    acc_addr = 16'h0000;
    {acc_wdata, port_a_dir, port_c_out, port_c_dir} = 32'h00000000;
    lag = 2'h0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    // reset values, reserved bits, unmapped and read-only places
    for (int i = 0; i < 3; i++) begin
      reg_acc(1'b0, {i[1:0], 2'h0}, 8'h00);
      check("reset value", q, 8'h00);
      reg_acc(1'b1, {i[1:0], 2'h0}, 8'hFF);
      reg_acc(1'b0, {i[1:0], 2'h0}, 8'h00);
      check("writable bits", q, (i == 0) ? 8'hFF : ((i == 1) ? 8'h7E : 8'h87));
      reg_acc(1'b1, {i[1:0], 2'h0}, 8'h00);
    end
    reg_acc(1'b1, OFS_STATUS, 8'hFF);
    reg_acc(1'b0, OFS_STATUS, 8'h00);
    check("status", q, 8'h00);
    reg_acc(1'b0, 4'h2, 8'h00);
    check("unmapped read", q, 8'h00);
    $display("test registers done");
    // interface off: pins follow the port settings, keeper independent of enable
    port_a_dir <= 8'h5A;
    port_c_dir <= 8'hC3;
    access(1'b1, 16'h2000, 8'h00, 1'b0);
    check("disabled strobes", rd_cnt + wr_cnt, 0);
    check("port a drive", ad_oe, 8'h5A);
    check("port c drive", high_address_oe, 8'hC3);
    check("strobe pins port", {latch_oe, rd_n_oe, wr_n_oe}, 3'h0);
    port_a_dir <= 8'h00;
    port_c_dir <= 8'h00;
    reg_acc(1'b1, OFS_CONTROL_B, 8'h80);
    repeat (2) @(posedge core_clk);
    check("keeper drive", ad_oe, 8'hFF);
    reg_acc(1'b1, OFS_CONTROL_B, 8'h00);
    repeat (2) @(posedge core_clk);
    check("keeper off", ad_oe, 8'h00);
    $display("test disabled done");
    // every wait code on the single sector, written then read back
    for (int k = 0; k < 4; k++) begin
      set_cfg(k[1:0], 2'h0, 3'h0);
      lag <= (k == 3) ? 2'h1 : 2'h0;
      access(1'b1, {14'h0C00, k[1:0]}, {6'h28, k[1:0]}, 1'b0);
      check("write strobe", wr_cnt, (k == 0) ? 1 : ((k == 1) ? 2 : 3));
      access(1'b0, {14'h0C00, k[1:0]}, 8'h00, 1'b0);
      if (k == 0) lat0 = lat;
      check("read strobe", rd_cnt, (k == 0) ? 1 : ((k == 1) ? 2 : 3));
      check("read latency", lat, lat0 + ((k == 3) ? 3 : k));
      check("read data", q, {6'h28, k[1:0]});
    end
    lag <= 2'h0;
    check("memory pins drive", {latch_oe, rd_n_oe, wr_n_oe}, 3'h7);
    $display("test wait codes done");
    // sector boundaries: lower sector two waits, upper none
    reg_acc(1'b1, OFS_MCU_CONTROL, 8'h80);
    for (int l = 1; l < 8; l++) begin
      reg_acc(1'b1, OFS_CONTROL_A, {1'b0, l[2:0], 4'h8});
      access(1'b1, {l[2:0], 13'h0000} - 16'h0001, 8'h11, 1'b0);
      check("lower sector", wr_cnt, 3);
      access(1'b1, {l[2:0], 13'h0000}, 8'h22, 1'b0);
      check("upper sector", wr_cnt, 1);
    end
    $display("test sectors done");
    // internal space and the trailing latch pulse
    reg_acc(1'b1, OFS_CONTROL_A, 8'h00);
    access(1'b1, 16'h10FF, 8'h66, 1'b0);
    check("internal strobes", rd_cnt + wr_cnt, 0);
    check("internal latch", ale_cnt != 0, 1);
    access(1'b1, INTERNAL_TOP, 8'h66, 1'b0);
    check("first external", wr_cnt, 1);
    access(1'b0, 16'h3000, 8'h00, 1'b0);
    a0 = ale_cnt;
    access(1'b0, 16'h3000, 8'h00, 1'b1);
    check("trailing latch", ale_cnt > a0, 1);
    $display("test internal done");
    // high mask: released pins fall back to a port direction of zero
    for (int m = 0; m < 8; m++) begin
      reg_acc(1'b1, OFS_CONTROL_B, {5'h00, m[2:0]});
      access(1'b1, 16'h4000, 8'h33, 1'b0);
      check("high drive", hoe_seen, (m == 7) ? 8'h00 : (8'hFF >> m));
    end
    // released top bits driven low by the port reach the bottom of the memory
    port_c_dir <= 8'hFF;
    reg_acc(1'b1, OFS_CONTROL_B, 8'h03);
    access(1'b1, 16'h2001, 8'hAA, 1'b0);
    reg_acc(1'b1, OFS_CONTROL_B, 8'h00);
    access(1'b1, 16'h2001, 8'h55, 1'b0);
    reg_acc(1'b1, OFS_CONTROL_B, 8'h03);
    access(1'b0, 16'h2001, 8'h00, 1'b0);
    check("masked read", q, 8'hAA);
    $display("test high mask done");
    // legacy mode: smaller internal space, one wait bit, no sectors
    legacy_mode <= 1'b1;
    reg_acc(1'b0, OFS_STATUS, 8'h00);
    check("legacy status", q, 8'h02);
    reg_acc(1'b1, OFS_CONTROL_A, 8'h7A);
    reg_acc(1'b1, OFS_MCU_CONTROL, 8'hC0);
    access(1'b1, INTERNAL_TOP_LEGACY, 8'h44, 1'b0);
    check("legacy one wait", wr_cnt, 2);
    reg_acc(1'b1, OFS_MCU_CONTROL, 8'h80);
    access(1'b1, INTERNAL_TOP_LEGACY, 8'h44, 1'b0);
    check("legacy no wait", wr_cnt, 1);
    access(1'b1, 16'h0FFF, 8'h44, 1'b0);
    check("legacy internal", wr_cnt, 0);
    $display("test legacy done");
    summarize();
  end
endmodule
`default_nettype wire
